/* File: shared/ddr4_cad_params.svh */
// Offsets, field positions, reset values and counts for the command/address decoder.
// Assumes inclusion by bare name from the design files.
`ifndef DDR4_CAD_PARAMS_SVH
`define DDR4_CAD_PARAMS_SVH
// Register byte offsets
`define CAD_OFS_CTRL 5'h00
`define CAD_OFS_STATUS 5'h04
`define CAD_OFS_MR1 5'h08
`define CAD_OFS_MR5 5'h0C
`define CAD_OFS_BANKS 5'h10
`define CAD_OFS_COUNTS 5'h14
// Reset values
`define CAD_CTRL_RST 2'h1
`define CAD_MR_RST 18'h00000
// Address pin functions
`define CAD_AP_BIT 10
`define CAD_BC_BIT 12
// Mode register fields
`define CAD_MR5_DM_BIT 10
`define CAD_MR5_WDBI_BIT 11
`define CAD_MR5_PAR_HI 2
`define CAD_MR1_TDQS_BIT 11
`define CAD_MR_SEL_MR1 3'h1
`define CAD_MR_SEL_MR5 3'h5
// Burst beat counts
`define CAD_BL_FULL 4'h8
`define CAD_BL_CHOP 4'h4
`endif

/* File: shared/ddr4_cad_pkg.sv */
// Types for the command/address decoder.
// Assumes nothing of its surroundings.
package ddr4_cad_pkg;
  typedef enum logic [3:0] {
    CMD_NOP = 4'h0, CMD_ACT = 4'h1, CMD_MRS = 4'h2, CMD_REF = 4'h3, CMD_PRE = 4'h4,
    CMD_RFU = 4'h5, CMD_WR = 4'h6, CMD_RD = 4'h7, CMD_ZQC = 4'h8
  } cmd_t;
  typedef enum logic [1:0] {W_X4 = 2'h0, W_X8 = 2'h1, W_X16 = 2'h2} dev_width_t;
  typedef enum logic [1:0] {WS_IDLE = 2'b01, WS_BURST = 2'b10} wr_state_t;
endpackage : ddr4_cad_pkg

/* File: shared/cad_beat_if.sv */
// Write beat carrier between the decoder and its mask/inversion unit.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface cad_beat_if;
  logic valid;
  logic [7:0] data;
  logic dm_n;
  logic dm_en;
  logic dbi_en;
  logic rst;
  logic out_valid;
  logic out_masked;
  logic [7:0] out_data;
  modport src (output valid, data, dm_n, dm_en, dbi_en, rst, input out_valid, out_masked, out_data);
  modport unit (input valid, data, dm_n, dm_en, dbi_en, rst, output out_valid, out_masked, out_data);
endinterface : cad_beat_if

/* File: verilog/cad_beat_unit.sv */
// Per-beat data mask and data bus inversion on write data.
// Assumes beats and mode flags come from logic on the same clock.
`timescale 1ns/1ps
module cad_beat_unit (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Beat carrier
  cad_beat_if.unit bif
);

  always_ff @(posedge i_clk) begin
    if (!i_nrst || bif.rst) begin
      bif.out_valid <= 1'b0;
      bif.out_masked <= 1'b0;
      bif.out_data <= 8'h00;
    end else begin
      bif.out_valid <= bif.valid && !(bif.dm_en && !bif.dm_n);
      bif.out_masked <= bif.valid && bif.dm_en && !bif.dm_n;
      if (bif.valid) begin
        bif.out_data <= (bif.dbi_en && !bif.dm_en && !bif.dm_n) ? ~bif.data : bif.data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  a_dbi_invert: assert property (@(posedge i_clk) disable iff (!i_nrst)
    bif.valid && !bif.rst && bif.dbi_en && !bif.dm_en && !bif.dm_n |=> bif.out_data == ~$past(bif.data))
    else $error("inverted beat not inverted");
  a_dbi_pass: assert property (@(posedge i_clk) disable iff (!i_nrst)
    bif.valid && !bif.rst && bif.dbi_en && !bif.dm_en && bif.dm_n |=> bif.out_data == $past(bif.data))
    else $error("true beat altered");

endmodule : cad_beat_unit

/* File: verilog/ddr4_cmd_addr_decode.sv */
// DDR4 command/address decoder with write beat mask/inversion and Avalon-MM status.
// Assumes pins are asynchronous to i_clk and CK is slow enough to be oversampled.
//
// Overview of operation
// - Command decoded from RAS_n, CAS_n, WE_n together with chip select.
// - ACT_n low makes RAS_n/CAS_n/WE_n row bits 16/15/14; high makes them commands.
// - A write beat sampled with mask low is discarded.
// - Mask sampled on both strobe edges, one value per beat.
// - Mask versus inversion function chosen by MR5 bits A10 and A11.
// - On x8, mask versus termination strobe chosen by MR1 bit A11.
// - With inversion on, pin low inverts data, pin high passes it.
// - Bank group inputs select target group of activate, read, write, precharge.
// - Bank address inputs select bank within the group for those commands.
// - Mode register set uses BG0 and bank address to select register.
// - x16 has one bank group input; x4 and x8 have two.
// - Row from address on activate, column on read/write; A17 only on x4.
// - Mode register set takes op-code from the address inputs.
// - A10 high on read/write precharges the bank afterward; low keeps it open.
// - Precharge with A10 high closes all banks, else only the selected one.
// - A12 low on read/write chops the burst; high runs full burst.
// - Reset pin low resets the device regardless of CK; controller holds it high.
// - Commands with chip select high are ignored.
// - Inputs sampled where true clock rises and complement clock is low.
// - When MR5 enables it, even parity is checked over command and address.
`timescale 1ns/1ps
`include "ddr4_cad_params.svh"
module ddr4_cmd_addr_decode #(
  parameter int NBANK = 16
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Memory pins
  input wire logic i_reset_n,
  input wire logic i_ck_t,
  input wire logic i_ck_c,
  input wire logic i_cs_n,
  input wire logic i_act_n,
  input wire logic i_ras_n_a16,
  input wire logic i_cas_n_a15,
  input wire logic i_we_n_a14,
  input wire logic [1:0] i_bg,
  input wire logic [1:0] i_ba,
  input wire logic i_a17,
  input wire logic [13:0] i_addr,
  input wire logic i_par,
  input wire logic i_dqs_t,
  input wire logic i_dm_n,
  input wire logic [7:0] i_dq,
  // Decoded command
  output logic o_cmd_valid,
  output logic [3:0] o_cmd,
  output logic [1:0] o_bg,
  output logic [1:0] o_ba,
  output logic [17:0] o_addr,
  output logic o_auto_pre,
  output logic o_burst_chop,
  output logic o_pre_all,
  output logic o_par_err,
  output logic o_in_reset,
  output logic [NBANK-1:0] o_bank_open,
  // Write data
  output logic o_wr_valid,
  output logic [7:0] o_wr_data,
  // Avalon-MM slave
  input wire logic [4:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  input wire logic [3:0] i_byteenable,
  output logic [31:0] o_readdata,
  output logic o_waitrequest
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser
  localparam int PW = 38;
  logic [PW-1:0] sync1_q;
  logic [PW-1:0] sync2_q;
  logic s_reset_n, s_ck_t, s_ck_c, s_dqs, s_dm_n, s_par, s_cs_n, s_act_n;
  logic s_ras_n, s_cas_n, s_we_n, s_a17;
  logic [7:0] s_dq;
  logic [1:0] s_bg, s_ba;
  logic [13:0] s_addr;
  logic ck_prev_q;
  logic dqs_prev_q;

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {i_reset_n, i_ck_t, i_ck_c, i_dqs_t, i_dm_n, i_dq, i_par, i_cs_n, i_act_n,
                  i_ras_n_a16, i_cas_n_a15, i_we_n_a14, i_bg, i_ba, i_a17, i_addr};
      sync2_q <= sync1_q;
    end
  end

  assign {s_reset_n, s_ck_t, s_ck_c, s_dqs, s_dm_n, s_dq, s_par, s_cs_n, s_act_n,
          s_ras_n, s_cas_n, s_we_n, s_bg, s_ba, s_a17, s_addr} = sync2_q;

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      ck_prev_q <= 1'b0;
      dqs_prev_q <= 1'b0;
    end else begin
      ck_prev_q <= s_ck_t;
      dqs_prev_q <= s_dqs;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command decode
  ddr4_cad_pkg::dev_width_t cfg_q;
  ddr4_cad_pkg::cmd_t dec_cmd;
  logic [17:0] mr1_q, mr5_q;
  logic rst_dev, ck_rise, par_bad, take;
  logic is_act, is_pre, is_rw, is_wr, is_mrs;
  logic s_a10, s_a12, a17_eff, tdqs_on;
  logic [1:0] bg_eff;
  logic [2:0] mr_sel;
  logic [3:0] bank_idx;
  logic [17:0] op_word, addr_sel;

  assign rst_dev = !s_reset_n;
  assign ck_rise = s_ck_t && !ck_prev_q && !s_ck_c;
  assign a17_eff = (cfg_q == ddr4_cad_pkg::W_X4) ? s_a17 : 1'b0;
  assign bg_eff = {(cfg_q == ddr4_cad_pkg::W_X16) ? 1'b0 : s_bg[1], s_bg[0]};
  assign bank_idx = {bg_eff, s_ba};
  assign mr_sel = {s_bg[0], s_ba};
  assign s_a10 = s_addr[`CAD_AP_BIT];
  assign s_a12 = s_addr[`CAD_BC_BIT];
  assign op_word = {a17_eff, 3'h0, s_addr};
  assign par_bad = (|mr5_q[`CAD_MR5_PAR_HI:0]) &&
                   (^{s_act_n, s_ras_n, s_cas_n, s_we_n, bg_eff, s_ba, a17_eff, s_addr, s_par});
  assign take = ck_rise && !s_cs_n && !par_bad && !rst_dev;

  always_comb begin
    dec_cmd = ddr4_cad_pkg::CMD_NOP;
    if (!s_act_n) begin
      dec_cmd = ddr4_cad_pkg::CMD_ACT;
    end else begin
      case ({s_ras_n, s_cas_n, s_we_n})
        3'h0: dec_cmd = ddr4_cad_pkg::CMD_MRS;
        3'h1: dec_cmd = ddr4_cad_pkg::CMD_REF;
        3'h2: dec_cmd = ddr4_cad_pkg::CMD_PRE;
        3'h3: dec_cmd = ddr4_cad_pkg::CMD_RFU;
        3'h4: dec_cmd = ddr4_cad_pkg::CMD_WR;
        3'h5: dec_cmd = ddr4_cad_pkg::CMD_RD;
        3'h6: dec_cmd = ddr4_cad_pkg::CMD_ZQC;
        default: dec_cmd = ddr4_cad_pkg::CMD_NOP;
      endcase
    end
  end

  assign is_act = (dec_cmd == ddr4_cad_pkg::CMD_ACT);
  assign is_pre = (dec_cmd == ddr4_cad_pkg::CMD_PRE);
  assign is_wr = (dec_cmd == ddr4_cad_pkg::CMD_WR);
  assign is_rw = is_wr || (dec_cmd == ddr4_cad_pkg::CMD_RD);
  assign is_mrs = (dec_cmd == ddr4_cad_pkg::CMD_MRS);

  always_comb begin
    if (is_act) begin
      addr_sel = {a17_eff, s_ras_n, s_cas_n, s_we_n, s_addr};
    end else if (is_rw) begin
      addr_sel = {8'h00, s_addr[9:0]};
    end else begin
      addr_sel = op_word;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst || rst_dev) begin
      o_cmd_valid <= 1'b0;
      o_par_err <= 1'b0;
      o_cmd <= ddr4_cad_pkg::CMD_NOP;
      o_bg <= 2'h0;
      o_ba <= 2'h0;
      o_addr <= 18'h00000;
      o_auto_pre <= 1'b0;
      o_burst_chop <= 1'b0;
      o_pre_all <= 1'b0;
    end else begin
      o_cmd_valid <= take && (dec_cmd != ddr4_cad_pkg::CMD_NOP);
      o_par_err <= ck_rise && !s_cs_n && par_bad;
      if (take) begin
        o_cmd <= dec_cmd;
        o_bg <= bg_eff;
        o_ba <= s_ba;
        o_addr <= addr_sel;
        o_auto_pre <= is_rw && s_a10;
        o_burst_chop <= is_rw && !s_a12;
        o_pre_all <= is_pre && s_a10;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_in_reset <= 1'b1;
    end else begin
      o_in_reset <= rst_dev;
    end
  end

  // Mode register shadows
  always_ff @(posedge i_clk) begin
    if (!i_nrst || rst_dev) begin
      mr1_q <= `CAD_MR_RST;
      mr5_q <= `CAD_MR_RST;
    end else if (take && is_mrs) begin
      if (mr_sel == `CAD_MR_SEL_MR1) begin
        mr1_q <= op_word;
      end
      if (mr_sel == `CAD_MR_SEL_MR5) begin
        mr5_q <= op_word;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bank open tracking
  genvar gi;
  generate
    for (gi = 0; gi < NBANK; gi++) begin : g_bank
      always_ff @(posedge i_clk) begin
        if (!i_nrst || rst_dev) begin
          o_bank_open[gi] <= 1'b0;
        end else if (take && is_act && bank_idx == 4'(gi)) begin
          o_bank_open[gi] <= 1'b1;
        end else if (take && is_pre && (s_a10 || bank_idx == 4'(gi))) begin
          o_bank_open[gi] <= 1'b0;
        end else if (take && is_rw && s_a10 && bank_idx == 4'(gi)) begin
          o_bank_open[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Write burst capture
  ddr4_cad_pkg::wr_state_t wst_q;
  logic [3:0] left_q;
  logic beat;
  cad_beat_if bif ();

  assign beat = (wst_q == ddr4_cad_pkg::WS_BURST) && (s_dqs != dqs_prev_q);
  assign tdqs_on = (cfg_q == ddr4_cad_pkg::W_X8) && mr1_q[`CAD_MR1_TDQS_BIT];

  always_ff @(posedge i_clk) begin
    if (!i_nrst || rst_dev) begin
      wst_q <= ddr4_cad_pkg::WS_IDLE;
      left_q <= 4'h0;
    end else begin
      case (wst_q)
        ddr4_cad_pkg::WS_IDLE: begin
          if (take && is_wr) begin
            wst_q <= ddr4_cad_pkg::WS_BURST;
            left_q <= s_a12 ? `CAD_BL_FULL : `CAD_BL_CHOP;
          end
        end
        ddr4_cad_pkg::WS_BURST: begin
          if (beat) begin
            left_q <= left_q - 4'h1;
            if (left_q == 4'h1) begin
              wst_q <= ddr4_cad_pkg::WS_IDLE;
            end
          end
        end
        default: wst_q <= ddr4_cad_pkg::WS_IDLE;
      endcase
    end
  end

  assign bif.valid = beat;
  assign bif.data = s_dq;
  assign bif.dm_n = s_dm_n;
  assign bif.dm_en = mr5_q[`CAD_MR5_DM_BIT] && !tdqs_on;
  assign bif.dbi_en = mr5_q[`CAD_MR5_WDBI_BIT] && !tdqs_on;
  assign bif.rst = rst_dev;
  assign o_wr_valid = bif.out_valid;
  assign o_wr_data = bif.out_data;

  cad_beat_unit u_beat (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .bif(bif)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Avalon-MM registers
  logic wr_en;
  logic cnt_clr;
  logic [15:0] par_cnt_q, mask_cnt_q;
  logic [31:0] rd_mux;

  assign wr_en = i_write && !o_waitrequest;
  assign cnt_clr = wr_en && (i_address == `CAD_OFS_COUNTS);

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_waitrequest <= 1'b1;
    end else begin
      o_waitrequest <= !((i_read || i_write) && o_waitrequest);
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      cfg_q <= ddr4_cad_pkg::dev_width_t'(`CAD_CTRL_RST);
    end else if (wr_en && i_address == `CAD_OFS_CTRL && i_byteenable[0]) begin
      cfg_q <= ddr4_cad_pkg::dev_width_t'(i_writedata[1:0]);
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      par_cnt_q <= 16'h0000;
      mask_cnt_q <= 16'h0000;
    end else begin
      if (o_par_err) begin
        par_cnt_q <= cnt_clr ? 16'h0001 : par_cnt_q + 16'h0001;
      end else if (cnt_clr) begin
        par_cnt_q <= 16'h0000;
      end
      if (bif.out_masked) begin
        mask_cnt_q <= cnt_clr ? 16'h0001 : mask_cnt_q + 16'h0001;
      end else if (cnt_clr) begin
        mask_cnt_q <= 16'h0000;
      end
    end
  end

  always_comb begin
    case (i_address)
      `CAD_OFS_CTRL: rd_mux = {30'h00000000, cfg_q};
      `CAD_OFS_STATUS: rd_mux = {26'h0000000, o_in_reset, wst_q[1], o_cmd};
      `CAD_OFS_MR1: rd_mux = {14'h0000, mr1_q};
      `CAD_OFS_MR5: rd_mux = {14'h0000, mr5_q};
      `CAD_OFS_BANKS: rd_mux = 32'(o_bank_open);
      `CAD_OFS_COUNTS: rd_mux = {mask_cnt_q, par_cnt_q};
      default: rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_readdata <= 32'h00000000;
    end else if (i_read && o_waitrequest) begin
      o_readdata <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  a_cmd_read_code: assert property (take && s_act_n && {s_ras_n, s_cas_n, s_we_n} == 3'h5
    |=> o_cmd_valid && o_cmd == ddr4_cad_pkg::CMD_RD) else $error("read not decoded");
  a_act_row_bits: assert property (take && !s_act_n
    |=> o_addr[16:14] == {$past(s_ras_n), $past(s_cas_n), $past(s_we_n)}) else $error("row bits wrong");
  a_mask_drop: assert property (beat && !rst_dev && bif.dm_en && !s_dm_n |=> !o_wr_valid)
    else $error("masked beat stored");
  a_burst_beats: assert property (take && is_wr && wst_q == ddr4_cad_pkg::WS_IDLE && !s_a12
    |=> left_q == 4'h4) else $error("chop burst length wrong");
  a_dm_off_pass: assert property (beat && !rst_dev && !mr5_q[10] && !mr5_q[11]
    |=> o_wr_valid && o_wr_data == $past(s_dq)) else $error("plain beat altered");
  a_tdqs_no_mask: assert property (beat && !rst_dev && tdqs_on && !s_dm_n |=> o_wr_valid)
    else $error("termination strobe masked data");
  a_bank_opened: assert property (take && is_act |=> o_bank_open[$past(bank_idx)])
    else $error("activated bank not open");
  a_mr5_write: assert property (take && is_mrs && mr_sel == 3'h5 |=> mr5_q == $past(op_word))
    else $error("MR5 shadow not written");
  a_x16_one_bg: assert property (o_cmd_valid && $past(cfg_q) == ddr4_cad_pkg::W_X16 |-> !o_bg[1])
    else $error("x16 used second group bit");
  a_a17_gate: assert property (o_cmd_valid && $past(cfg_q) != ddr4_cad_pkg::W_X4 |-> !o_addr[17])
    else $error("A17 passed on non-x4");
  a_auto_pre: assert property (take && is_rw |=> o_auto_pre == $past(s_a10))
    else $error("auto precharge flag wrong");
  a_pre_all: assert property (take && is_pre && s_a10 |=> o_bank_open == '0)
    else $error("precharge all left bank open");
  a_reset_pin: assert property (rst_dev |=> !o_cmd_valid && o_bank_open == '0 && !o_wr_valid && o_in_reset)
    else $error("pin reset ignored");
  a_cs_masked: assert property (ck_rise && s_cs_n |=> !o_cmd_valid)
    else $error("deselected command taken");
  a_par_block: assert property (ck_rise && !s_cs_n && par_bad && !rst_dev |=> o_par_err && !o_cmd_valid)
    else $error("parity error not flagged");

  c_activate: cover property (take && is_act ##1 o_cmd_valid);
  c_masked_beat: cover property (bif.out_masked);
  c_parity_err: cover property (o_par_err);

endmodule : ddr4_cmd_addr_decode

/* File: sim/cad_ctrl_model.sv */
// Controller-side model that drives the memory command, address and write data pins.
// Assumes i_clk from the bench; every pin changes just after a rising edge of it.
`timescale 1ns/1ps
module cad_ctrl_model (
  // Clock
  input wire logic i_clk,
  // Memory pins
  output logic o_reset_n,
  output logic o_ck_t,
  output logic o_ck_c,
  output logic o_cs_n,
  output logic o_act_n,
  output logic [2:0] o_rcw,
  output logic [1:0] o_bg,
  output logic [1:0] o_ba,
  output logic o_a17,
  output logic [13:0] o_addr,
  output logic o_par,
  output logic o_dqs_t,
  output logic o_dm_n,
  output logic [7:0] o_dq
);
  logic x16 = 1'b0;
  initial begin
    o_reset_n = 1'b1;
    o_ck_t = 1'b0;
    o_ck_c = 1'b1;
    o_cs_n = 1'b1;
    o_act_n = 1'b1;
    o_rcw = 3'h7;
    o_bg = 2'h0;
    o_ba = 2'h0;
    o_a17 = 1'b0;
    o_addr = 14'h0000;
    o_par = 1'b0;
    o_dqs_t = 1'b0;
    o_dm_n = 1'b1;
    o_dq = 8'h00;
  end
  ////////////////////////////////////////////////////////////////////////////
  // One command per clock rise, pins held around it; bad flips the parity bit
  task automatic cmd(input logic cs_n, act_n, input logic [2:0] rcw, input logic [1:0] bg, ba,
                     input logic [13:0] a, input logic bad);
    @(posedge i_clk);
    o_cs_n <= cs_n;
    o_act_n <= act_n;
    o_rcw <= rcw;
    o_bg <= bg;
    o_ba <= ba;
    o_addr <= a;
    o_par <= ^{act_n, rcw, bg[1] & !x16, bg[0], ba, o_a17, a} ^ bad;
    repeat (4) @(posedge i_clk);
    o_ck_t <= 1'b1;
    o_ck_c <= 1'b0;
    repeat (4) @(posedge i_clk);
    o_ck_t <= 1'b0;
    o_ck_c <= 1'b1;
    repeat (4) @(posedge i_clk);
    o_cs_n <= 1'b1;
    o_rcw <= ~rcw;
    o_addr <= ~a;
  endtask : cmd
  // One write beat on a strobe edge, data turned over once its hold runs out
  task automatic beat(input logic dm_n, input logic [7:0] d);
    @(posedge i_clk);
    o_dm_n <= dm_n;
    o_dq <= d;
    repeat (2) @(posedge i_clk);
    o_dqs_t <= ~o_dqs_t;
    repeat (4) @(posedge i_clk);
    o_dq <= ~d;
  endtask : beat
  task automatic hold_reset(input logic v);
    @(posedge i_clk);
    o_reset_n <= v;
    repeat (6) @(posedge i_clk);
  endtask : hold_reset
endmodule : cad_ctrl_model

/* File: sim/ddr4_cmd_addr_decode_test.sv */
// Self-checking bench for the command/address decoder.
// Assumes the design files and cad_ctrl_model are compiled before it.
`timescale 1ns/1ps
module ddr4_cmd_addr_decode_test;
  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic [4:0] address = 5'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic reset_n, ck_t, ck_c, cs_n, act_n, a17, par, dqs_t, dm_n;
  logic [2:0] rcw;
  logic [1:0] bg, ba, bg_o, ba_o;
  logic [13:0] pin_a;
  logic [7:0] dq, wr_data;
  logic cmd_valid, auto_pre, chop, pre_all, par_err, in_reset, wr_valid, waitrequest;
  logic [3:0] cmd;
  logic [17:0] addr_o;
  logic [15:0] bank_open;
  logic [15:0] banks = 16'h0;
  logic [31:0] readdata, r;
  logic [29:0] cq[$];
  logic [7:0] wq[$];
  logic [31:0] rq[$];
  int mismatches = 0;
  int comparisons = 0;
  int masked = 0;
  int cycles = 0;
  initial begin
    forever #10 i_clk = ~i_clk;
  end
  cad_ctrl_model ctl (.i_clk(i_clk), .o_reset_n(reset_n), .o_ck_t(ck_t), .o_ck_c(ck_c), .o_cs_n(cs_n),
    .o_act_n(act_n), .o_rcw(rcw), .o_bg(bg), .o_ba(ba), .o_a17(a17), .o_addr(pin_a), .o_par(par),
    .o_dqs_t(dqs_t), .o_dm_n(dm_n), .o_dq(dq));
  ddr4_cmd_addr_decode #(.NBANK(16)) dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_reset_n(reset_n),
    .i_ck_t(ck_t), .i_ck_c(ck_c), .i_cs_n(cs_n), .i_act_n(act_n), .i_ras_n_a16(rcw[2]),
    .i_cas_n_a15(rcw[1]), .i_we_n_a14(rcw[0]), .i_bg(bg), .i_ba(ba), .i_a17(a17), .i_addr(pin_a),
    .i_par(par), .i_dqs_t(dqs_t), .i_dm_n(dm_n), .i_dq(dq), .o_cmd_valid(cmd_valid), .o_cmd(cmd),
    .o_bg(bg_o), .o_ba(ba_o), .o_addr(addr_o), .o_auto_pre(auto_pre), .o_burst_chop(chop),
    .o_pre_all(pre_all), .o_par_err(par_err), .o_in_reset(in_reset), .o_bank_open(bank_open),
    .o_wr_valid(wr_valid), .o_wr_data(wr_data), .i_address(address), .i_read(read), .i_write(write),
    .i_writedata(writedata), .i_byteenable(4'hF), .o_readdata(readdata), .o_waitrequest(waitrequest));
  ////////////////////////////////////////////////////////////////////////////
  task automatic note(input logic [31:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : note
  task automatic cmp_cmd(input logic [29:0] got, exp);
    note({2'b0, got}, {2'b0, exp});
  endtask : cmp_cmd
  task automatic cmp_wr(input logic [7:0] got, exp);
    note({24'h0, got}, {24'h0, exp});
  endtask : cmp_wr
  task automatic cmp_reg(input logic [31:0] got, exp);
    note(got, exp);
  endtask : cmp_reg
  task automatic results();
    if (mismatches == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results
  always @(posedge i_clk) begin
    cycles++;
    if (cmd_valid === 1'b1 || par_err === 1'b1) begin
      cmp_cmd(par_err ? {1'b1, 29'h0} : {1'b0, cmd, bg_o, ba_o, addr_o, auto_pre, chop, pre_all},
              cq.size() != 0 ? cq.pop_front() : 30'hx);
    end
    if (wr_valid === 1'b1) begin
      cmp_wr(wr_data, wq.size() != 0 ? wq.pop_front() : 8'hx);
    end
    if (read && waitrequest === 1'b0) begin
      cmp_reg(readdata, rq.size() != 0 ? rq.pop_front() : 32'hx);
    end
    if (cycles == 10000) begin
      mismatches++;
      results();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d, exp);
    if (!w) rq.push_back(exp);
    @(posedge i_clk);
    address <= a;
    read <= !w;
    write <= w;
    writedata <= d;
    do begin
      @(posedge i_clk);
    end while (waitrequest !== 1'b0);
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus
  task automatic go(input logic cs_n, act_n, input logic [2:0] rcw, input logic [1:0] bg, ba,
                    input logic [13:0] a, input logic bad);
    logic [3:0] c;
    logic [1:0] g;
    logic [17:0] ad;
    logic rw;
    c = act_n ? 4'h2 + {1'b0, rcw} : 4'h1;
    g = {bg[1] & !ctl.x16, bg[0]};
    rw = c == 4'h6 || c == 4'h7;
    ad = !act_n ? {1'b0, rcw, a} : rw ? {8'h00, a[9:0]} : {4'h0, a};
    if (bad) begin
      cq.push_back({1'b1, 29'h0});
    end else if (!cs_n && c != 4'h9) begin
      cq.push_back({1'b0, c, g, ba, ad, rw & a[10], rw & !a[12], c == 4'h4 && a[10]});
      if (c == 4'h1) banks[{g, ba}] = 1'b1;
      if (c == 4'h4 && a[10]) banks = 16'h0;
      else if (c == 4'h4 || (rw && a[10])) banks[{g, ba}] = 1'b0;
    end
    ctl.cmd(cs_n, act_n, rcw, bg, ba, a, bad);
  endtask : go
  task automatic burst(input int n, input logic dm, dbi);
    logic m;
    logic [7:0] d;
    for (int i = 0; i < n; i++) begin
      m = $urandom;
      d = $urandom;
      if (!(dm && !m)) wq.push_back(dbi && !m ? ~d : d);
      if (dm && !m) masked++;
      ctl.beat(m, d);
    end
  endtask : burst
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h77bb));
    repeat (3) @(posedge i_clk);
    i_nrst <= 1'b1;
    repeat (5) @(posedge i_clk);
    bus(0, 5'h00, 0, 32'h1);
    bus(0, 5'h18, 0, 32'h0);
    for (int k = 0; k < 16; k++) begin
      r = $urandom;
      go(0, k[2:0] != 3'h7, k[2:0], k[2:0] == 3'h0 ? 2'b00 : r[15:14], k[2:0] == 3'h0 ? 2'b00 : r[17:16],
         r[13:0], 0);
      if (k[2:0] == 3'h4) burst(r[12] ? 8 : 4, 0, 0);
    end
    bus(0, 5'h04, 0, 32'h1);
    bus(0, 5'h10, 0, {16'h0, banks});
    cmp_reg({16'h0, bank_open}, {16'h0, banks});
    go(0, 1, 3'h2, 2'b00, 2'b00, 14'h0400, 0);
    go(1, 0, 3'h5, 2'b10, 2'b01, 14'h0155, 0);
    bus(0, 5'h10, 0, 32'h0);
    go(0, 1, 3'h0, 2'b01, 2'b01, 14'h0401, 0);
    bus(0, 5'h0C, 0, 32'h00401);
    go(0, 0, 3'h1, 2'b10, 2'b11, 14'h1234, 1);
    go(0, 0, 3'h6, 2'b01, 2'b10, 14'h2F0F, 0);
    go(0, 1, 3'h4, 2'b00, 2'b10, 14'h1000, 0);
    burst(8, 1, 0);
    bus(0, 5'h14, 0, {masked[15:0], 16'h1});
    bus(1, 5'h14, 0, 0);
    bus(0, 5'h14, 0, 32'h0);
    go(0, 1, 3'h0, 2'b01, 2'b01, 14'h0801, 0);
    go(0, 1, 3'h4, 2'b10, 2'b01, 14'h0400, 0);
    burst(4, 0, 1);
    go(0, 1, 3'h0, 2'b00, 2'b01, 14'h0800, 0);
    bus(0, 5'h08, 0, 32'h00800);
    go(0, 1, 3'h4, 2'b11, 2'b00, 14'h1000, 0);
    burst(8, 0, 0);
    bus(1, 5'h00, 32'h2, 0);
    ctl.x16 = 1'b1;
    go(0, 0, 3'h3, 2'b11, 2'b10, 14'h0ABC, 0);
    bus(0, 5'h04, 0, 32'h1);
    ctl.hold_reset(0);
    cmp_reg({15'h0, in_reset, bank_open}, 32'h00010000);
    bus(0, 5'h04, 0, 32'h20);
    ctl.hold_reset(1);
    bus(0, 5'h0C, 0, 32'h0);
    bus(0, 5'h10, 0, 32'h0);
    bus(0, 5'h00, 0, 32'h2);
    cmp_reg({15'h0, in_reset, bank_open}, 32'h00000000);
    repeat (4) @(posedge i_clk);
    cmp_reg(cq.size() + wq.size() + rq.size(), 32'h0);
    results();
  end
endmodule : ddr4_cmd_addr_decode_test
